// ==== cfl_defines.vh ====
// constants shared by the configuration load port
`ifndef CFL_DEFINES_VH
`define CFL_DEFINES_VH
`define CFL_ADDR_CTRL 8'h00
`define CFL_ADDR_LEN 8'h04
`define CFL_ADDR_STAT 8'h08
`define CFL_ADDR_CNT 8'h0C
`define CFL_CTRL_W 11
`define CFL_CTRL_RST 11'h000
`define CFL_LEN_RST 24'h000000
`define CFL_B_MODE 0
`define CFL_B_WIDE 1
`define CFL_B_COMP 2
`define CFL_B_ENC 3
`define CFL_B_X4 4
`define CFL_B_SEL_LO 5
`define CFL_B_SEL_HI 6
`define CFL_B_MULTI 7
`define CFL_B_REMOTE 8
`define CFL_B_USRCLK 9
`define CFL_B_INITEN 10
`define CFL_CLK_MHZ 100
`define CFL_STATUS_MIN_US 268
`define CFL_CD2UM_MIN_US 175
`define CFL_INIT_CYCLE_COUNT 17408
`define CFL_POR_CYC 1000
`define CFL_LOAD_CLOCK_MAX_MHZ 125
`define CFL_CD2CU_PERIODS 4
`define CFL_END_FALLS 2'h2
`define CFL_HALF_12M5 3'h4
`define CFL_HALF_25M 3'h2
`define CFL_HALF_50M 3'h1
`define CFL_AS_CMD 32'h03000000
`define CFL_AS_CMD_BITS 6'h20
`define CFL_BYTE_BITS 4'h8
`endif

// ==== cfl_sync.v ====
// three-stage synchroniser, a change counts once stages two and three agree
`timescale 1ns/10ps
module cfl_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q_ff
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  genvar i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q_ff[i] <= INIT[i];
        end else if (s2_ff[i] == s3_ff[i]) begin
          q_ff[i] <= s3_ff[i];
        end
      end
    end
  endgenerate
endmodule // cfl_sync

// ==== cfl_asdiv.v ====
// divider making the active serial load clock and its edge pulses
`timescale 1ns/10ps
module cfl_asdiv (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [2:0] half,
  output reg clk_ff,
  output reg rise_ff,
  output reg fall_ff
);
  reg [2:0] cnt_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
      clk_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      if (!run) begin
        // parks low at once, so a pause can cut a high phase short
        cnt_ff <= 3'h0;
        clk_ff <= 1'b0;
      end else if (cnt_ff + 3'h1 >= half) begin
        cnt_ff <= 3'h0;
        clk_ff <= ~clk_ff;
        rise_ff <= ~clk_ff;
        fall_ff <= clk_ff;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end
endmodule // cfl_asdiv

// ==== cfl_load_port.v ====
// configuration load port: reset handshake, passive parallel and active serial loading, init timing
`timescale 1ns/10ps
`include "cfl_defines.vh"
module cfl_load_port #(
  parameter [17:0] STATUS_MIN_CYC = `CFL_STATUS_MIN_US * `CFL_CLK_MHZ,
  parameter [17:0] POR_CYC = `CFL_POR_CYC,
  parameter [17:0] OSC_INIT_CYC = `CFL_CD2UM_MIN_US * `CFL_CLK_MHZ,
  parameter [17:0] INIT_CYCLE_COUNT_CYC = `CFL_INIT_CYCLE_COUNT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire config_req_n,
  input wire status_n_in,
  output reg status_n_out,
  output reg status_n_oe,
  input wire load_complete_in,
  output reg load_complete_out,
  output reg load_complete_oe,
  input wire load_clock_in,
  output reg load_clock_out,
  output reg load_clock_oe,
  input wire [15:0] load_data,
  input wire [3:0] serial_flash_data,
  output reg serial_flash_cmd_out,
  output reg serial_flash_sel_n,
  input wire user_init_clock,
  output reg init_done_out,
  output reg init_done_oe,
  output reg user_mode,
  output reg [15:0] cfg_word,
  output reg cfg_word_valid
);
  localparam [2:0] ST_POR = 3'h0;
  localparam [2:0] ST_RESET = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;
  localparam [2:0] ST_INIT = 3'h4;
  localparam [2:0] ST_USER = 3'h5;
  localparam [17:0] CD2CU_CYC = (`CFL_CD2CU_PERIODS * `CFL_CLK_MHZ + `CFL_LOAD_CLOCK_MAX_MHZ - 1) / `CFL_LOAD_CLOCK_MAX_MHZ;

  reg [2:0] state_ff;
  reg [17:0] cnt_ff;
  reg [`CFL_CTRL_W-1:0] ctrl_ff;
  reg [23:0] len_ff;
  reg [23:0] units_ff;
  reg [1:0] phase_ff;
  reg [1:0] falls_ff;
  reg uclk_en_ff;
  reg run_ff;
  reg [31:0] cmd_sh_ff;
  reg [5:0] cmd_cnt_ff;
  reg [7:0] byte_ff;
  reg [3:0] bits_ff;
  reg lclk_d_ff;
  reg uclk_d_ff;

  wire req_q;
  wire [1:0] pin_q;
  wire lclk_q;
  wire uclk_q;
  wire [15:0] data_q;
  wire [3:0] fdat_q;
  wire as_clk;
  wire as_rise;
  wire as_fall;

  cfl_sync #(.W(1), .INIT(1'b1)) u_req (.clk(pclk), .rst_n(presetn), .d(config_req_n), .q_ff(req_q));
  cfl_sync #(.W(2), .INIT(2'h0)) u_pin (.clk(pclk), .rst_n(presetn), .d({load_complete_in, status_n_in}),
    .q_ff(pin_q));
  cfl_sync #(.W(1), .INIT(1'b0)) u_lclk (.clk(pclk), .rst_n(presetn), .d(load_clock_in), .q_ff(lclk_q));
  cfl_sync #(.W(1), .INIT(1'b0)) u_uclk (.clk(pclk), .rst_n(presetn), .d(user_init_clock), .q_ff(uclk_q));
  // data passes the same depth as the clock so a word lines up with its edge
  cfl_sync #(.W(16), .INIT(16'h0000)) u_data (.clk(pclk), .rst_n(presetn), .d(load_data), .q_ff(data_q));
  cfl_sync #(.W(4), .INIT(4'h0)) u_fdat (.clk(pclk), .rst_n(presetn), .d(serial_flash_data), .q_ff(fdat_q));

  wire stat_q = pin_q[0];
  wire as_mode = ctrl_ff[`CFL_B_MODE];
  wire lclk_rise = lclk_q & ~lclk_d_ff;
  wire lclk_fall = ~lclk_q & lclk_d_ff;
  wire uclk_rise = uclk_q & ~uclk_d_ff;

  // the top setting cannot be reached from a 100 MHz clock, so it runs at the 50 MHz step
  function [2:0] half_of;
    input [`CFL_CTRL_W-1:0] c;
    begin
      if (c[`CFL_B_REMOTE]) begin
        half_of = `CFL_HALF_12M5;
      end else begin
        case (c[`CFL_B_SEL_HI:`CFL_B_SEL_LO])
          2'h0: half_of = `CFL_HALF_12M5;
          2'h1: half_of = `CFL_HALF_25M;
          default: half_of = `CFL_HALF_50M;
        endcase
      end
    end
  endfunction

  function [1:0] last_phase;
    input [`CFL_CTRL_W-1:0] c;
    begin
      if (c[`CFL_B_COMP]) begin
        last_phase = c[`CFL_B_WIDE] ? 2'h3 : 2'h1;
      end else if (c[`CFL_B_WIDE] && c[`CFL_B_ENC]) begin
        last_phase = 2'h1;
      end else begin
        last_phase = 2'h0;
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CFL_ADDR_CTRL) || (a == `CFL_ADDR_LEN) || (a == `CFL_ADDR_STAT) || (a == `CFL_ADDR_CNT);
    end
  endfunction

  cfl_asdiv u_div (
    .clk(pclk),
    .rst_n(presetn),
    .run(run_ff),
    .half(half_of(ctrl_ff)),
    .clk_ff(as_clk),
    .rise_ff(as_rise),
    .fall_ff(as_fall)
  );

  // one word gathered this cycle, from either scheme
  reg got_word;
  reg [15:0] new_word;
  reg [7:0] nxt_byte;
  always @* begin
    got_word = 1'b0;
    new_word = 16'h0000;
    nxt_byte = ctrl_ff[`CFL_B_X4] ? {byte_ff[3:0], fdat_q} : {byte_ff[6:0], fdat_q[1]};
    if (state_ff == ST_LOAD && stat_q) begin
      if (!as_mode && lclk_rise && phase_ff == 2'h0) begin
        got_word = 1'b1;
        new_word = ctrl_ff[`CFL_B_WIDE] ? data_q : {8'h00, data_q[7:0]};
      end else if (as_mode && as_fall && cmd_cnt_ff == 6'h00) begin
        got_word = (bits_ff + (ctrl_ff[`CFL_B_X4] ? 4'h4 : 4'h1)) == `CFL_BYTE_BITS;
        new_word = {8'h00, nxt_byte};
      end
    end
  end

  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;

  // slave answers one cycle after setup; read data and error are registered then
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_ff <= `CFL_CTRL_RST;
      len_ff <= `CFL_LEN_RST;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped(paddr);
      if (apb_setup) begin
        case (paddr)
          `CFL_ADDR_CTRL: prdata <= {21'h000000, ctrl_ff};
          `CFL_ADDR_LEN: prdata <= {8'h00, len_ff};
          `CFL_ADDR_STAT: prdata <= {25'h0000000, pin_q, user_mode, state_ff, 1'b0};
          `CFL_ADDR_CNT: prdata <= {8'h00, units_ff};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (apb_wr && paddr == `CFL_ADDR_CTRL) begin
        ctrl_ff <= pwdata[`CFL_CTRL_W-1:0];
      end
      if (apb_wr && paddr == `CFL_ADDR_LEN) begin
        len_ff <= pwdata[23:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_d_ff <= 1'b0;
      uclk_d_ff <= 1'b0;
      load_clock_out <= 1'b0;
    end else begin
      lclk_d_ff <= lclk_q;
      uclk_d_ff <= uclk_q;
      load_clock_out <= as_clk;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_POR;
      cnt_ff <= 18'h00000;
      units_ff <= 24'h000000;
      phase_ff <= 2'h0;
      falls_ff <= 2'h0;
      uclk_en_ff <= 1'b0;
      run_ff <= 1'b0;
      cmd_sh_ff <= `CFL_AS_CMD;
      cmd_cnt_ff <= `CFL_AS_CMD_BITS;
      byte_ff <= 8'h00;
      bits_ff <= 4'h0;
      status_n_out <= 1'b0;
      status_n_oe <= 1'b1;
      load_complete_out <= 1'b0;
      load_complete_oe <= 1'b1;
      load_clock_oe <= 1'b0;
      serial_flash_cmd_out <= 1'b0;
      serial_flash_sel_n <= 1'b1;
      init_done_out <= 1'b0;
      init_done_oe <= 1'b0;
      user_mode <= 1'b0;
      cfg_word <= 16'h0000;
      cfg_word_valid <= 1'b0;
    end else begin
      cfg_word_valid <= got_word;
      if (got_word) begin
        cfg_word <= new_word;
      end
      load_clock_oe <= as_mode && (state_ff == ST_LOAD || state_ff == ST_DONE);
      if (!req_q && state_ff != ST_POR && state_ff != ST_RESET) begin
        state_ff <= ST_RESET;
        cnt_ff <= 18'h00000;
        status_n_oe <= 1'b1;
        load_complete_oe <= 1'b1;
        init_done_oe <= 1'b0;
        user_mode <= 1'b0;
        run_ff <= 1'b0;
        serial_flash_sel_n <= 1'b1;
      end else begin
        case (state_ff)
          ST_POR: begin
            if (cnt_ff >= POR_CYC) begin
              state_ff <= ST_RESET;
              cnt_ff <= 18'h00000;
            end else begin
              cnt_ff <= cnt_ff + 18'h00001;
            end
          end
          ST_RESET: begin
            // a request held low stretches this phase, no upper bound of our own
            if (cnt_ff >= STATUS_MIN_CYC && req_q) begin
              state_ff <= ST_LOAD;
              status_n_oe <= 1'b0;
              cnt_ff <= 18'h00000;
              units_ff <= 24'h000000;
              phase_ff <= 2'h0;
              cmd_sh_ff <= `CFL_AS_CMD;
              cmd_cnt_ff <= `CFL_AS_CMD_BITS;
              bits_ff <= 4'h0;
              serial_flash_cmd_out <= 1'b0;
            end else if (cnt_ff < STATUS_MIN_CYC) begin
              cnt_ff <= cnt_ff + 18'h00001;
            end
          end
          ST_LOAD: begin
            // an externally held status line blocks loading until it is let go
            if (as_mode && stat_q && serial_flash_sel_n) begin
              serial_flash_sel_n <= 1'b0;
              serial_flash_cmd_out <= cmd_sh_ff[31];
              run_ff <= 1'b1;
            end
            if (!as_mode && stat_q && lclk_rise) begin
              phase_ff <= (phase_ff == last_phase(ctrl_ff)) ? 2'h0 : phase_ff + 2'h1;
            end
            if (as_mode && as_fall && !serial_flash_sel_n) begin
              if (cmd_cnt_ff != 6'h00) begin
                cmd_sh_ff <= {cmd_sh_ff[30:0], 1'b0};
                serial_flash_cmd_out <= cmd_sh_ff[30];
                cmd_cnt_ff <= cmd_cnt_ff - 6'h01;
              end else begin
                byte_ff <= nxt_byte;
                bits_ff <= got_word ? 4'h0 : bits_ff + (ctrl_ff[`CFL_B_X4] ? 4'h4 : 4'h1);
              end
            end
            if (got_word) begin
              units_ff <= units_ff + 24'h000001;
              if (units_ff + 24'h000001 >= len_ff) begin
                state_ff <= ST_DONE;
                load_complete_oe <= 1'b0;
                falls_ff <= 2'h0;
                init_done_oe <= ctrl_ff[`CFL_B_INITEN];
              end
            end
          end
          ST_DONE: begin
            if (as_mode ? as_fall : lclk_fall) begin
              falls_ff <= falls_ff + 2'h1;
              if (falls_ff + 2'h1 == `CFL_END_FALLS) begin
                state_ff <= ST_INIT;
                cnt_ff <= 18'h00000;
                uclk_en_ff <= 1'b0;
                run_ff <= 1'b0;
                serial_flash_sel_n <= 1'b1;
              end
            end
          end
          ST_INIT: begin
            if (!ctrl_ff[`CFL_B_USRCLK]) begin
              if (cnt_ff + 18'h00001 >= OSC_INIT_CYC) begin
                state_ff <= ST_USER;
              end else begin
                cnt_ff <= cnt_ff + 18'h00001;
              end
            end else if (!uclk_en_ff) begin
              if (cnt_ff + 18'h00001 >= CD2CU_CYC) begin
                uclk_en_ff <= 1'b1;
                cnt_ff <= 18'h00000;
              end else begin
                cnt_ff <= cnt_ff + 18'h00001;
              end
            end else if (uclk_rise) begin
              if (cnt_ff + 18'h00001 >= INIT_CYCLE_COUNT_CYC) begin
                state_ff <= ST_USER;
              end else begin
                cnt_ff <= cnt_ff + 18'h00001;
              end
            end
          end
          ST_USER: begin
            user_mode <= 1'b1;
            init_done_oe <= 1'b0;
          end
          default: begin
            state_ff <= ST_RESET;
            cnt_ff <= 18'h00000;
          end
        endcase
      end
    end
  end
endmodule // cfl_load_port

// ==== cfl_load_port_sva.sv ====
// assertion checker for the configuration load port
`timescale 1ns/10ps
module cfl_load_port_sva #(
  parameter [17:0] STATUS_MIN_CYC = 200,
  parameter [17:0] POR_CYC = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire config_req_n,
  input wire status_n_oe,
  input wire load_complete_oe,
  input wire load_clock_out,
  input wire serial_flash_cmd_out,
  input wire serial_flash_sel_n,
  input wire user_mode,
  input wire cfg_word_valid
);
  reg [17:0] low_cnt_ff;
  reg [17:0] rel_cnt_ff;
  // counts how long status is held and how long it outlives a high request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_ff <= 18'h0;
      rel_cnt_ff <= 18'h0;
    end else begin
      low_cnt_ff <= status_n_oe ? low_cnt_ff + 18'h1 : 18'h0;
      rel_cnt_ff <= (status_n_oe && config_req_n) ? rel_cnt_ff + 18'h1 : 18'h0;
    end
  end
  a_req_drops_lines: assert property (@(posedge pclk) disable iff (!presetn)
    user_mode && !config_req_n && $past(config_req_n) |-> ##[1:6] (status_n_oe && load_complete_oe))
    else $error("status or done not pulled low after request");
  a_status_min_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_n_oe) |-> low_cnt_ff >= STATUS_MIN_CYC)
    else $error("status released too early");
  a_status_max_hold: assert property (@(posedge pclk) disable iff (!presetn)
    rel_cnt_ff <= STATUS_MIN_CYC + POR_CYC + 18'h8)
    else $error("status held too long after request high");
  a_user_lines_high: assert property (@(posedge pclk) disable iff (!presetn)
    user_mode |-> !status_n_oe && !load_complete_oe)
    else $error("line pulled low in user mode");
  a_done_on_word: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(load_complete_oe) |-> cfg_word_valid || $past(cfg_word_valid))
    else $error("done released without a final unit");
  a_cmd_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_flash_sel_n && !$past(serial_flash_sel_n) && $changed(serial_flash_cmd_out)
    |-> $fell(load_clock_out) || ($past(load_clock_out, 2) && !$past(load_clock_out)))
    else $error("serial command changed off the falling edge");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_apb_err_map: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("apb error flag wrong for address");
  a_valid_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_word_valid |=> !cfg_word_valid)
    else $error("word valid longer than one cycle");
endmodule // cfl_load_port_sva
bind cfl_load_port cfl_load_port_sva #(.STATUS_MIN_CYC(STATUS_MIN_CYC), .POR_CYC(POR_CYC)) cfl_load_port_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .config_req_n(config_req_n), .status_n_oe(status_n_oe), .load_complete_oe(load_complete_oe),
  .load_clock_out(load_clock_out), .serial_flash_cmd_out(serial_flash_cmd_out),
  .serial_flash_sel_n(serial_flash_sel_n), .user_mode(user_mode), .cfg_word_valid(cfg_word_valid));

// ==== cfl_host_model.sv ====
// host controller and serial flash stand-in for the load port
`timescale 1ns/10ps
module cfl_host_model (
  output reg config_req_n,
  output reg load_clock_in,
  output reg [15:0] load_data,
  output reg [3:0] serial_flash_data,
  input wire load_clock_out,
  input wire serial_flash_sel_n
);
  reg [15:0] words [0:3];
  initial begin
    config_req_n = 1'b1;
    load_clock_in = 1'b0;
    load_data = 16'h0000;
    serial_flash_data = 4'h0;
  end
  // deselected flash lines toggle so a stale value never reads serial_flash_data
  always #10 if (serial_flash_sel_n) serial_flash_data = ~serial_flash_data;
  // a new read starts from a known nibble so the bench can predict the bytes
  always @(negedge serial_flash_sel_n) serial_flash_data <= 4'h0;
  always @(negedge load_clock_out) if (!serial_flash_sel_n) serial_flash_data <= serial_flash_data + 4'h3;
  task pulse_req(input integer ns);
    begin
      config_req_n = 1'b0;
      #(ns);
      config_req_n = 1'b1;
    end
  endtask
  task clk_cycle;
    begin
      load_clock_in = 1'b1;
      #80;
      load_clock_in = 1'b0;
      #80;
    end
  endtask
  task send(input integer n, input integer ratio);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        load_data = words[i];
        #20;
        repeat (ratio) clk_cycle;
      end
      repeat (2) clk_cycle;
      load_data = ~load_data;
    end // clock parked low, never floating
  endtask
endmodule // cfl_host_model

// ==== cfl_load_port_tb_top.sv ====
// self-checking bench for the configuration load port
`timescale 1ns/10ps
module cfl_load_port_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg user_init_clock = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, config_req_n, status_n_out, status_n_oe, load_complete_out, load_complete_oe;
  wire load_clock_in, load_clock_out, load_clock_oe, serial_flash_cmd_out, serial_flash_sel_n;
  wire init_done_out, init_done_oe, user_mode, cfg_word_valid;
  wire [15:0] load_data, cfg_word;
  wire [3:0] serial_flash_data;
  // open-drain lines with pull-ups
  wire status_n_in = status_n_oe ? status_n_out : 1'b1;
  wire load_complete_in = load_complete_oe ? load_complete_out : 1'b1;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer n;
  logic [31:0] rd;
  logic er;
  logic [31:0] cmd;
  always #5 pclk = ~pclk;
  always #37 user_init_clock = ~user_init_clock;
  cfl_load_port #(.STATUS_MIN_CYC(18'd200), .POR_CYC(18'd20), .OSC_INIT_CYC(18'd100), .INIT_CYCLE_COUNT_CYC(18'd16))
    cfl_load_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_req_n(config_req_n), .status_n_in(status_n_in), .status_n_out(status_n_out),
    .status_n_oe(status_n_oe), .load_complete_in(load_complete_in), .load_complete_out(load_complete_out),
    .load_complete_oe(load_complete_oe), .load_clock_in(load_clock_in), .load_clock_out(load_clock_out),
    .load_clock_oe(load_clock_oe), .load_data(load_data), .serial_flash_data(serial_flash_data),
    .serial_flash_cmd_out(serial_flash_cmd_out), .serial_flash_sel_n(serial_flash_sel_n),
    .user_init_clock(user_init_clock), .init_done_out(init_done_out), .init_done_oe(init_done_oe),
    .user_mode(user_mode), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid));
  cfl_host_model cfl_host_model_inst (.config_req_n(config_req_n), .load_clock_in(load_clock_in),
    .load_data(load_data), .serial_flash_data(serial_flash_data), .load_clock_out(load_clock_out),
    .serial_flash_sel_n(serial_flash_sel_n));
  task wrap_up;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task count_until_user;
    begin
      n = 0;
      while (user_mode !== 1'b1) begin
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask
  task restart(input logic [31:0] ctrl, input logic [31:0] len);
    begin
      apb(1'b1, 8'h00, ctrl);
      apb(1'b1, 8'h04, len);
      n = 0;
      fork
        cfl_host_model_inst.pulse_req(2000);
        while (status_n_oe !== 1'b1 && n < 300) begin
          @(posedge pclk);
          n = n + 1;
        end
      join
      check("req_to_low", 1, n <= 6);
      check("done_low", 1, load_complete_oe);
      check("pull_levels", 0, {status_n_out, load_complete_out, init_done_out});
      n = 0;
      while (status_n_oe === 1'b1) begin
        @(posedge pclk);
        n = n + 1;
      end
      check("status_release", 1, n <= 12);
      // the device clocks itself in active serial loading
      if (!ctrl[0]) #2000;
    end
  endtask
  task collect(input integer cnt, input logic [15:0] mask);
    integer k;
    begin
      for (k = 0; k < cnt; k = k + 1) begin
        @(posedge pclk);
        while (cfg_word_valid !== 1'b1) @(posedge pclk);
        check("cfg_word", {16'h0, cfl_host_model_inst.words[k] & mask}, {16'h0, cfg_word});
      end
    end
  endtask
  task t_por_regs;
    begin
      n = 0;
      while (status_n_oe === 1'b1) begin
        @(posedge pclk);
        n = n + 1;
      end
      check("por_hold", 1, n >= 221 && n <= 232);
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl_reset", 32'h0, rd);
      apb(1'b0, 8'h04, 32'h0);
      check("len_reset", 32'h0, rd);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped_err", 1, er);
      check("unmapped_data", 32'h0, rd);
    end
  endtask
  task t_fpp16;
    begin
      cfl_host_model_inst.words[0] = 16'hA55A;
      cfl_host_model_inst.words[1] = 16'h0FF0;
      cfl_host_model_inst.words[2] = 16'h8001;
      restart(32'h006, 32'h3);
      fork
        cfl_host_model_inst.send(3, 4);
        collect(3, 16'hFFFF);
        begin
          while (load_complete_oe !== 1'b0) @(posedge pclk);
          count_until_user;
        end
      join
      check("done_released", 0, load_complete_oe);
      check("osc_init_time", 1, n >= 100 && n <= 249);
      apb(1'b0, 8'h0C, 32'h0);
      check("unit_count", 32'h3, rd);
      apb(1'b0, 8'h08, 32'h0);
      check("user_stat", 32'h7A, rd);
    end
  endtask
  task t_fpp8_usr;
    begin
      cfl_host_model_inst.words[0] = 16'h3CC3;
      cfl_host_model_inst.words[1] = 16'hF00F;
      restart(32'h604, 32'h2);
      fork
        cfl_host_model_inst.send(2, 2);
        collect(2, 16'h00FF);
        begin
          while (load_complete_oe !== 1'b0) @(posedge pclk);
          check("init_pin_low", 1, init_done_oe);
          n = 0;
          while (user_mode !== 1'b1) @(posedge user_init_clock or posedge user_mode) n = n + 1;
        end
      join
      check("user_clk_init", 1, n >= 17 && n <= 26);
      @(posedge pclk);
      check("init_pin_free", 0, init_done_oe);
    end
  endtask
  task t_active_serial;
    begin
      restart(32'h1D1, 32'h2);
      while (serial_flash_sel_n !== 1'b0) @(posedge pclk);
      check("as_clk_drive", 1, load_clock_oe);
      repeat (32) begin
        @(posedge load_clock_out);
        cmd = {cmd[30:0], serial_flash_cmd_out};
      end
      check("flash_cmd", 32'h03000000, cmd);
      @(posedge pclk);
      n = 0;
      while (load_clock_out === 1'b1) begin
        @(posedge pclk);
        n = n + 1;
      end
      check("slow_half", 4, n);
      n = 0;
      while (load_complete_oe === 1'b1) begin
        @(posedge pclk);
        n = n + cfg_word_valid;
      end
      check("serial_units", 2, n);
      check("serial_byte", 32'h69, {16'h0, cfg_word});
      count_until_user;
      check("serial_user", 1, user_mode);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_por_regs;
    t_fpp16;
    t_fpp8_usr;
    t_active_serial;
    wrap_up;
  end
endmodule // cfl_load_port_tb_top
